// [common/swf_pkg.sv]
// shared constants and carriers for the status word flag block
package swf_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// widths
	localparam int ACC_W = 8;
	localparam int STAT_W = 8;
	localparam int BANK_W = 2;
	localparam int REG_IDX_W = 3;
	localparam int RAM_ADDR_W = 8;
	localparam int BIT_SEL_W = 3;

	////////////////////////////////////////////////////////////////////////////////
	// status byte field positions
	localparam int STAT_PAR_BIT = 0;
	localparam int STAT_UF_BIT = 1;
	localparam int STAT_OVF_BIT = 2;
	localparam int STAT_BANK_LO_BIT = 3;
	localparam int STAT_BANK_HI_BIT = 4;

	// the same positions at the width of the bit selector they meet
	localparam logic [BIT_SEL_W-1:0] SEL_PAR = 3'h0;
	localparam logic [BIT_SEL_W-1:0] SEL_UF = 3'h1;
	localparam logic [BIT_SEL_W-1:0] SEL_OVF = 3'h2;
	localparam logic [BIT_SEL_W-1:0] SEL_BANK_LO = 3'h3;
	localparam logic [BIT_SEL_W-1:0] SEL_BANK_HI = 3'h4;

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [BANK_W-1:0] BANK_RST = 2'h0;
	localparam logic OVF_RST = 1'h0;
	localparam logic UF_RST = 1'h0;
	localparam logic PAR_RST = 1'h0;
	localparam logic [RAM_ADDR_W-1:0] RAM_ADDR_RST = 8'h00;
	localparam logic [STAT_W-1:0] STAT_RST = 8'h00;

	// bits above the bank field are not held here and read as zero
	localparam int STAT_PAD_W = STAT_W - STAT_BANK_HI_BIT - 1;
	localparam logic [STAT_PAD_W-1:0] STAT_PAD = 3'h0;
	localparam int RAM_PAD_W = RAM_ADDR_W - BANK_W - REG_IDX_W;
	localparam logic [RAM_PAD_W-1:0] RAM_PAD = 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef enum logic [1:0] {
		SWF_OP_ADD = 2'h0,
		SWF_OP_SUB = 2'h1,
		SWF_OP_MUL = 2'h2,
		SWF_OP_DIV = 2'h3
	} swf_arith_op_t;

	typedef struct packed {
		logic valid;
		swf_arith_op_t op;
		logic carry;
		logic borrow;
		logic mul_ovf;
		logic div_ovf;
	} swf_alu_res_t;

	typedef struct packed {
		logic byte_wr;
		logic [STAT_W-1:0] byte_data;
		logic bit_wr;
		logic [BIT_SEL_W-1:0] bit_sel;
		logic bit_val;
	} swf_sw_wr_t;

	typedef struct packed {
		logic valid;
		logic [REG_IDX_W-1:0] idx;
	} swf_reg_req_t;

endpackage : swf_pkg

// [logic/swf_parity_reg.sv]
// registered even/odd parity of a data word
`timescale 1ns/1ns
module swf_parity_reg #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// data in
	input wire logic [W-1:0] data,
	// parity out
	output logic parity
);

	logic parity_reg;
	logic parity_next;

	////////////////////////////////////////////////////////////////////////////////
	// odd count of ones reads one, even reads zero
	always_comb
	begin
		parity_next = ^data;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			parity_reg <= swf_pkg::PAR_RST;
		else
			parity_reg <= parity_next;
	end

	assign parity = parity_reg;

endmodule : swf_parity_reg

// [logic/swf_status_flags.sv]
// status word flags: bank select decode, overflow, user flag, parity
`timescale 1ns/1ns
module swf_status_flags (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// alu result and accumulator
	input wire swf_pkg::swf_alu_res_t alu_res,
	input wire logic [swf_pkg::ACC_W-1:0] acc,
	// software writes and reads of the status byte
	input wire swf_pkg::swf_sw_wr_t sw_wr,
	input wire logic sw_rd,
	output logic [swf_pkg::STAT_W-1:0] rd_data,
	output logic rd_valid,
	// working register address request
	input wire swf_pkg::swf_reg_req_t reg_req,
	output logic [swf_pkg::RAM_ADDR_W-1:0] ram_addr,
	output logic ram_addr_valid,
	// flag outputs
	output logic bank_select_high,
	output logic bank_select_low,
	output logic [swf_pkg::RAM_ADDR_W-1:0] bank_base_addr,
	output logic arith_overflow_flag,
	output logic user_flag_one,
	output logic parity_flag
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [swf_pkg::BANK_W-1:0] bank_reg;
	logic [swf_pkg::BANK_W-1:0] bank_next;
	logic [swf_pkg::RAM_ADDR_W-1:0] bank_base_reg;
	logic [swf_pkg::RAM_ADDR_W-1:0] bank_base_next;
	logic ovf_reg;
	logic ovf_next;
	logic uf_reg;
	logic uf_next;
	logic ovf_cause;
	logic [swf_pkg::RAM_ADDR_W-1:0] ram_addr_reg;
	logic [swf_pkg::RAM_ADDR_W-1:0] ram_addr_next;
	logic ram_addr_valid_reg;
	logic ram_addr_valid_next;
	logic [swf_pkg::STAT_W-1:0] rd_data_reg;
	logic [swf_pkg::STAT_W-1:0] rd_data_next;
	logic rd_valid_reg;
	logic rd_valid_next;
	logic par_q;

	////////////////////////////////////////////////////////////////////////////////
	// bank selector
	// a bit write to the same field in the same cycle wins over the byte write
	always_comb
	begin
		bank_next = bank_reg;
		if (sw_wr.byte_wr)
		begin
			bank_next[0] = sw_wr.byte_data[swf_pkg::STAT_BANK_LO_BIT];
			bank_next[1] = sw_wr.byte_data[swf_pkg::STAT_BANK_HI_BIT];
		end
		if (sw_wr.bit_wr && sw_wr.bit_sel == swf_pkg::SEL_BANK_LO)
			bank_next[0] = sw_wr.bit_val;
		if (sw_wr.bit_wr && sw_wr.bit_sel == swf_pkg::SEL_BANK_HI)
			bank_next[1] = sw_wr.bit_val;
		// base is bank times eight, one clean range per bank
		bank_base_next = {swf_pkg::RAM_PAD, bank_next, {swf_pkg::REG_IDX_W{1'b0}}};
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			bank_reg <= swf_pkg::BANK_RST;
			bank_base_reg <= swf_pkg::RAM_ADDR_RST;
		end
		else
		begin
			bank_reg <= bank_next;
			bank_base_reg <= bank_base_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// overflow flag
	// the alu result beats a software write in the same cycle: the flag
	// must describe the latest arithmetic result
	always_comb
	begin
		ovf_cause = 1'b0;
		unique case (alu_res.op)
			swf_pkg::SWF_OP_ADD: ovf_cause = alu_res.carry;
			swf_pkg::SWF_OP_SUB: ovf_cause = alu_res.borrow;
			swf_pkg::SWF_OP_MUL: ovf_cause = alu_res.mul_ovf;
			swf_pkg::SWF_OP_DIV: ovf_cause = alu_res.div_ovf;
		endcase
		ovf_next = ovf_reg;
		if (sw_wr.byte_wr)
			ovf_next = sw_wr.byte_data[swf_pkg::STAT_OVF_BIT];
		if (sw_wr.bit_wr && sw_wr.bit_sel == swf_pkg::SEL_OVF)
			ovf_next = sw_wr.bit_val;
		if (alu_res.valid)
			ovf_next = ovf_cause;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			ovf_reg <= swf_pkg::OVF_RST;
		else
			ovf_reg <= ovf_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// user flag one
	// no hardware event reaches this bit, so alu_res is not looked at
	always_comb
	begin
		uf_next = uf_reg;
		if (sw_wr.byte_wr)
			uf_next = sw_wr.byte_data[swf_pkg::STAT_UF_BIT];
		if (sw_wr.bit_wr && sw_wr.bit_sel == swf_pkg::SEL_UF)
			uf_next = sw_wr.bit_val;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			uf_reg <= swf_pkg::UF_RST;
		else
			uf_reg <= uf_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// parity of the accumulator
	// one cycle behind the accumulator; writes to this bit are dropped
	swf_parity_reg #(
		.W(swf_pkg::ACC_W)
	) u_parity (
		.clk(clk),
		.resetn(resetn),
		.data(acc),
		.parity(par_q)
	);

	////////////////////////////////////////////////////////////////////////////////
	// working register address
	// uses the bank held before any write of the same cycle
	always_comb
	begin
		ram_addr_valid_next = reg_req.valid;
		ram_addr_next = ram_addr_reg;
		if (reg_req.valid)
			ram_addr_next = {swf_pkg::RAM_PAD, bank_reg, reg_req.idx};
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ram_addr_reg <= swf_pkg::RAM_ADDR_RST;
			ram_addr_valid_reg <= 1'b0;
		end
		else
		begin
			ram_addr_reg <= ram_addr_next;
			ram_addr_valid_reg <= ram_addr_valid_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status byte read
	// shows the flags as held before this cycle's writes
	always_comb
	begin
		rd_valid_next = sw_rd;
		rd_data_next = rd_data_reg;
		if (sw_rd)
		begin
			rd_data_next = swf_pkg::STAT_RST;
			rd_data_next[swf_pkg::STAT_BANK_HI_BIT] = bank_reg[1];
			rd_data_next[swf_pkg::STAT_BANK_LO_BIT] = bank_reg[0];
			rd_data_next[swf_pkg::STAT_OVF_BIT] = ovf_reg;
			rd_data_next[swf_pkg::STAT_UF_BIT] = uf_reg;
			rd_data_next[swf_pkg::STAT_PAR_BIT] = par_q;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rd_data_reg <= swf_pkg::STAT_RST;
			rd_valid_reg <= 1'b0;
		end
		else
		begin
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from flops
	assign bank_select_high = bank_reg[1];
	assign bank_select_low = bank_reg[0];
	assign bank_base_addr = bank_base_reg;
	assign arith_overflow_flag = ovf_reg;
	assign user_flag_one = uf_reg;
	assign parity_flag = par_q;
	assign ram_addr = ram_addr_reg;
	assign ram_addr_valid = ram_addr_valid_reg;
	assign rd_data = rd_data_reg;
	assign rd_valid = rd_valid_reg;

endmodule : swf_status_flags

// [verification/swf_alu_model.sv]
// arithmetic unit model feeding the flag block
`timescale 1ns/1ns
module swf_alu_model (
	// clock
	input wire logic clk,
	// command from the bench
	input wire logic go,
	input wire swf_pkg::swf_arith_op_t op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	// result side
	output swf_pkg::swf_alu_res_t alu_res,
	output logic [7:0] acc
);
	logic [15:0] r;
	always_comb
	begin
		case (op)
			swf_pkg::SWF_OP_ADD: r = a + b;
			swf_pkg::SWF_OP_SUB: r = a - b;
			swf_pkg::SWF_OP_MUL: r = a * b;
			default: r = (b == 8'h00) ? 16'hffff : 16'(a / b);
		endcase
	end
	// all four causes offered every time, so the core must pick by op
	always_ff @(posedge clk)
	begin
		alu_res <= {go, op, r[8], a < b, |r[15:8], b == 8'h00};
		if (go)
			acc <= r[7:0];
	end
endmodule : swf_alu_model

// [verification/swf_status_flags_assertions.sv]
// concurrent checks on the status word flag ports
`timescale 1ns/1ns
module swf_status_flags_chk (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// inputs
	input wire swf_pkg::swf_alu_res_t alu_res,
	input wire logic [7:0] acc,
	input wire swf_pkg::swf_sw_wr_t sw_wr,
	input wire logic sw_rd,
	input wire swf_pkg::swf_reg_req_t reg_req,
	// outputs
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	input wire logic [7:0] ram_addr,
	input wire logic ram_addr_valid,
	input wire logic bank_select_high,
	input wire logic bank_select_low,
	input wire logic [7:0] bank_base_addr,
	input wire logic arith_overflow_flag,
	input wire logic user_flag_one,
	input wire logic parity_flag
);
	logic cause;
	logic acc_odd;
	assign acc_odd = ^acc;
	always_comb
	begin
		case (alu_res.op)
			swf_pkg::SWF_OP_ADD: cause = alu_res.carry;
			swf_pkg::SWF_OP_SUB: cause = alu_res.borrow;
			swf_pkg::SWF_OP_MUL: cause = alu_res.mul_ovf;
			default: cause = alu_res.div_ovf;
		endcase
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	chk_bank_base: assert property (bank_base_addr == {3'h0, bank_select_high, bank_select_low, 3'h0})
		else $error("bank base wrong");
	chk_reg_addr: assert property (reg_req.valid |=> ram_addr_valid && ram_addr ==
		{3'h0, $past(bank_select_high), $past(bank_select_low), $past(reg_req.idx)})
		else $error("register address wrong");
	chk_ovf_set: assert property (alu_res.valid && cause |=> arith_overflow_flag)
		else $error("overflow not set");
	chk_ovf_clear: assert property (alu_res.valid && !cause |=> !arith_overflow_flag)
		else $error("overflow not cleared");
	chk_user_hold: assert property (!sw_wr.byte_wr && !sw_wr.bit_wr |=> $stable(user_flag_one))
		else $error("user flag moved");
	chk_par_odd: assert property ($past(resetn) && $past(acc_odd) |-> parity_flag)
		else $error("parity odd wrong");
	chk_par_even: assert property ($past(resetn) && !$past(acc_odd) |-> !parity_flag)
		else $error("parity even wrong");
	chk_read_back: assert property (sw_rd |=> rd_valid && rd_data == {3'h0, $past(bank_select_high),
		$past(bank_select_low), $past(arith_overflow_flag), $past(user_flag_one), $past(parity_flag)})
		else $error("read data wrong");
	// both strobes are single-cycle answers, never held over
	chk_rd_pulse: assert property (!sw_rd |=> !rd_valid)
		else $error("read valid held");
	chk_addr_pulse: assert property (!reg_req.valid |=> !ram_addr_valid)
		else $error("address valid held");
	cov_req: cover property (reg_req.valid);
	cov_ovf: cover property (alu_res.valid && cause);
	cov_rd: cover property (sw_rd);
	cov_par: cover property (parity_flag);
endmodule : swf_status_flags_chk
bind swf_status_flags swf_status_flags_chk swf_status_flags_chk_inst (.clk(clk), .resetn(resetn),
	.alu_res(alu_res), .acc(acc), .sw_wr(sw_wr), .sw_rd(sw_rd), .reg_req(reg_req),
	.rd_data(rd_data), .rd_valid(rd_valid), .ram_addr(ram_addr), .ram_addr_valid(ram_addr_valid),
	.bank_select_high(bank_select_high), .bank_select_low(bank_select_low),
	.bank_base_addr(bank_base_addr), .arith_overflow_flag(arith_overflow_flag),
	.user_flag_one(user_flag_one), .parity_flag(parity_flag));

// [verification/tb_top.sv]
// self-checking bench for the status word flag block
`timescale 1ns/1ns
module tb_top;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic go = 1'b0;
	swf_pkg::swf_arith_op_t op = swf_pkg::SWF_OP_ADD;
	logic [7:0] a = 8'h00;
	logic [7:0] b = 8'h00;
	swf_pkg::swf_alu_res_t alu_res;
	logic [7:0] acc;
	swf_pkg::swf_sw_wr_t sw_wr = '0;
	logic sw_rd = 1'b0;
	swf_pkg::swf_reg_req_t reg_req = '0;
	logic [7:0] rd_data, ram_addr, bank_base_addr;
	logic rd_valid, ram_addr_valid, bank_select_high, bank_select_low;
	logic arith_overflow_flag, user_flag_one, parity_flag;
	int err_count = 0;
	int total_checks = 0;
	always #2 clk = ~clk;
	swf_alu_model swf_alu_model_inst (.clk(clk), .go(go), .op(op), .a(a), .b(b),
		.alu_res(alu_res), .acc(acc));
	swf_status_flags swf_status_flags_inst (.clk(clk), .resetn(resetn), .alu_res(alu_res),
		.acc(acc), .sw_wr(sw_wr), .sw_rd(sw_rd), .rd_data(rd_data), .rd_valid(rd_valid),
		.reg_req(reg_req), .ram_addr(ram_addr), .ram_addr_valid(ram_addr_valid),
		.bank_select_high(bank_select_high), .bank_select_low(bank_select_low),
		.bank_base_addr(bank_base_addr), .arith_overflow_flag(arith_overflow_flag),
		.user_flag_one(user_flag_one), .parity_flag(parity_flag));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e)
		begin
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
			err_count++;
		end
	endtask : chk
	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	task alu(input swf_pkg::swf_arith_op_t o, input logic [7:0] x, input logic [7:0] y);
		@(posedge clk);
		go <= 1'b1;
		op <= o;
		a <= x;
		b <= y;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		#1;
	endtask : alu
	task swr(input logic bw, input logic [7:0] d, input logic bt, input logic [2:0] s, input logic v);
		@(posedge clk);
		sw_wr <= {bw, d, bt, s, v};
		@(posedge clk);
		sw_wr <= '0;
		#1;
	endtask : swr
	task rd(input logic [7:0] e);
		@(posedge clk);
		sw_rd <= 1'b1;
		@(posedge clk);
		sw_rd <= 1'b0;
		#1;
		chk({7'h0, rd_valid}, 8'h01);
		chk(rd_data, e);
	endtask : rd
	////////////////////////////////////////////////////////////////////////////////
	task t_bank;
		for (int i = 0; i < 4; i++)
		begin
			swr(1'b1, {3'h0, i[1:0], 3'h0}, 1'b0, 3'h0, 1'b0);
			chk(bank_base_addr, 8'(i * 8));
			chk({6'h0, bank_select_high, bank_select_low}, 8'(i));
			@(posedge clk);
			reg_req <= {1'b1, 3'h7};
			@(posedge clk);
			reg_req <= '0;
			#1;
			chk({7'h0, ram_addr_valid}, 8'h01);
			chk(ram_addr, 8'(i * 8 + 7));
		end
		$display("bank test done");
	endtask : t_bank
	task ovf(input swf_pkg::swf_arith_op_t o, input logic [7:0] x, input logic [7:0] y, input logic e);
		alu(o, x, y);
		chk({7'h0, arith_overflow_flag}, {7'h0, e});
	endtask : ovf
	task t_ovf;
		ovf(swf_pkg::SWF_OP_ADD, 8'hc8, 8'h64, 1'b1);
		ovf(swf_pkg::SWF_OP_ADD, 8'h01, 8'h02, 1'b0);
		ovf(swf_pkg::SWF_OP_SUB, 8'h01, 8'h02, 1'b1);
		ovf(swf_pkg::SWF_OP_SUB, 8'h05, 8'h02, 1'b0);
		ovf(swf_pkg::SWF_OP_MUL, 8'h10, 8'h10, 1'b1);
		ovf(swf_pkg::SWF_OP_MUL, 8'h03, 8'h04, 1'b0);
		ovf(swf_pkg::SWF_OP_DIV, 8'h05, 8'h00, 1'b1);
		ovf(swf_pkg::SWF_OP_DIV, 8'h09, 8'h03, 1'b0);
		$display("overflow test done");
	endtask : t_ovf
	task t_par;
		logic [7:0] v[4];
		logic [3:0] odd;
		v = '{8'h07, 8'h96, 8'hff, 8'h80};
		// counted by hand: three, four, eight and one set bits
		odd = 4'h9;
		foreach (v[i])
		begin
			alu(swf_pkg::SWF_OP_ADD, v[i], 8'h00);
			chk({7'h0, parity_flag}, {7'h0, odd[i]});
		end
		$display("parity test done");
	endtask : t_par
	task t_user;
		swr(1'b0, 8'h00, 1'b1, 3'h1, 1'b1);
		chk({7'h0, user_flag_one}, 8'h01);
		alu(swf_pkg::SWF_OP_ADD, 8'hc8, 8'h64);
		rd(8'h1f);
		// parity bit in the byte must be ignored
		swr(1'b1, 8'h00, 1'b0, 3'h0, 1'b0);
		rd(8'h01);
		$display("user flag test done");
	endtask : t_user
	// parity, read byte and address are nonzero here, so a lost reset shows
	task t_reset;
		@(posedge clk);
		resetn <= 1'b0;
		@(posedge clk);
		#1;
		chk({bank_select_high, bank_select_low, arith_overflow_flag, user_flag_one, parity_flag,
			rd_valid, ram_addr_valid, 1'b0}, 8'h00);
		chk(bank_base_addr, 8'h00);
		chk(ram_addr, 8'h00);
		chk(rd_data, 8'h00);
		@(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		#1;
		chk({7'h0, parity_flag}, 8'h01);
		$display("reset test done");
	endtask : t_reset
	initial
	begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		t_bank();
		t_ovf();
		t_par();
		t_user();
		t_reset();
		tally_and_finish();
	end
	initial
	begin
		#100000;
		err_count++;
		tally_and_finish();
	end
endmodule : tb_top
